// ===== src/bpdma_pkg.sv
package bpdma_pkg;
   // Register indices; these printed offsets are not word aligned, so the
   // byte address on the register port is four times the index
   localparam logic [7:0] BPDMA_IDX_DMA_CTRL = 8'h53;
   localparam logic [7:0] BPDMA_IDX_BUF_SIZE = 8'h54;
   localparam logic [7:0] BPDMA_IDX_RESET    = 8'h59;
   localparam logic [7:0] BPDMA_IDX_RP_LO    = 8'h5a;
   localparam logic [7:0] BPDMA_IDX_RP_HI    = 8'h5b;
   localparam logic [7:0] BPDMA_IDX_WP_LO    = 8'h5c;
   localparam logic [7:0] BPDMA_IDX_WP_HI    = 8'h5d;
   localparam logic [7:0] BPDMA_IDX_SP_LO    = 8'h5e;
   localparam logic [7:0] BPDMA_IDX_SP_HI    = 8'h5f;
   localparam logic [7:0] BPDMA_IDX_LATCH    = 8'h60;
   localparam int         BPDMA_ADDR_W       = 10;
   // DMA control field positions
   localparam int BPDMA_BIT_ACK    = 1;
   localparam int BPDMA_BIT_H2B    = 2;
   localparam int BPDMA_BIT_B2H    = 3;
   localparam int BPDMA_BIT_DIR    = 4;
   localparam int BPDMA_BIT_DONE   = 5;
   // Reset values
   localparam logic [7:0]  BPDMA_CTRL_RST  = 8'h00;
   localparam logic [15:0] BPDMA_PTR_RST   = 16'h0000;
   localparam logic [15:0] BPDMA_SIZE_RST  = 16'hffff;
   typedef enum logic [1:0] {
      BPDMA_HS_IDLE, BPDMA_HS_REQ, BPDMA_HS_WAIT_REL
   } bpdma_hs_t;
endpackage

// ===== src/bpdma_mem.sv
`timescale 1ns/10ps
module bpdma_mem #(
   parameter int AW = 16,
   parameter int DW = 8
) (
   // Clock
   input  wire logic          clk,
   // Port A: device side
   input  wire logic          a_we,
   input  wire logic [AW-1:0] a_addr,
   input  wire logic [DW-1:0] a_wdata,
   output logic      [DW-1:0] a_rdata,
   // Port B: host side
   input  wire logic          b_we,
   input  wire logic [AW-1:0] b_addr,
   input  wire logic [DW-1:0] b_wdata,
   output logic      [DW-1:0] b_rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Each port writes only its own accesses; a same-address clash is
   // left to the pointer discipline of the sequencer.
   always_ff @(posedge clk) begin
      if (a_we) begin
         mem[a_addr] <= a_wdata;
      end
      a_rdata <= mem[a_addr];
   end

   always_ff @(posedge clk) begin
      if (b_we) begin
         mem[b_addr] <= b_wdata;
      end
      b_rdata <= mem[b_addr];
   end
endmodule // bpdma_mem

// ===== src/bpdma_seq.sv
`timescale 1ns/10ps
module bpdma_seq
   import bpdma_pkg::*;
#(
   parameter int PW = 16
) (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // Register port
   input  wire logic [BPDMA_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   // Disk device side
   input  wire logic                    device_byte_strobe,
   input  wire logic [7:0]              dev_wdata,
   output logic      [7:0]              dev_rdata,
   // Host side REQ/ACK
   input  wire logic                    host_ack,
   input  wire logic [7:0]              host_wdata,
   output logic                         host_req,
   output logic      [7:0]              host_rdata,
   // External address latch image (high pointer bytes)
   output logic      [7:0]              ext_latch
);
   import bpdma_pkg::*;

   logic [7:0]    ctrl_reg, ctrl_next;
   logic [PW-1:0] rp_reg, rp_next, wp_reg, wp_next, sp_reg, sp_next;
   logic [PW-1:0] size_reg, size_next;
   logic [7:0]    latch_reg, latch_next;
   logic [31:0]   rdata_reg, rdata_next;
   bpdma_hs_t     hs_reg, hs_next;
   logic [2:0]    strb_sync_reg, ack_sync_reg;
   logic [7:0]    dev_data_reg;
   logic [7:0]    host_data_reg;

   logic          strb_edge, ack_s, wr_hit, rd_ok;
   logic [7:0]    a_word, wbyte;
   logic [7:0]    dev_q, host_q;
   logic          mem_a_we, mem_b_we;
   logic [PW-1:0] rp_inc, wp_inc;

   // Pins come from outside the clock domain: two flops on strobe and ACK before use, one on the data pins
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         strb_sync_reg <= 3'h0;
         ack_sync_reg  <= 3'h0;
         dev_data_reg  <= 8'h00;
         host_data_reg <= 8'h00;
      end else begin
         strb_sync_reg <= {strb_sync_reg[1:0], device_byte_strobe};
         ack_sync_reg  <= {ack_sync_reg[1:0], host_ack};
         dev_data_reg  <= dev_wdata;
         host_data_reg <= host_wdata;
      end
   end

   assign strb_edge = strb_sync_reg[1] & ~strb_sync_reg[2];
   assign ack_s     = ack_sync_reg[1];
   assign a_word    = reg_addr[BPDMA_ADDR_W-1:2];
   assign wbyte     = reg_wdata[7:0];
   assign wr_hit    = reg_wr & (reg_addr[1:0] == 2'h0);

   // Wrap after the configured last address
   function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p,
                                              input logic [PW-1:0] lim);
      wrap_inc = (p >= lim) ? '0 : p + 1'b1;
   endfunction

   assign rp_inc = wrap_inc(rp_reg, size_reg);
   assign wp_inc = wrap_inc(wp_reg, size_reg);

   // Device strobe: write buffer when direction set, read otherwise
   assign mem_a_we = strb_edge & ctrl_reg[BPDMA_BIT_DIR];
   // Host handshake writes into the buffer on ACK in host-to-buffer mode
   assign mem_b_we = (hs_reg == BPDMA_HS_REQ) & ack_s
                     & ctrl_reg[BPDMA_BIT_H2B];

   bpdma_mem #(.AW(PW), .DW(8)) u_mem (
      .clk     (core_clk),
      .a_we    (mem_a_we),
      .a_addr  (wp_reg),
      .a_wdata (dev_data_reg),
      .a_rdata (dev_q),
      .b_we    (mem_b_we),
      .b_addr  (ctrl_reg[BPDMA_BIT_B2H] ? rp_reg : wp_reg),
      .b_wdata (host_data_reg),
      .b_rdata (host_q)
   );

   // Buffer-to-host only when direction set; the done flag stops new host requests, not device strobes
   assign rd_ok = ctrl_reg[BPDMA_BIT_B2H] & ctrl_reg[BPDMA_BIT_DIR];

   always_comb begin
      ctrl_next  = ctrl_reg;
      rp_next    = rp_reg;
      wp_next    = wp_reg;
      sp_next    = sp_reg;
      size_next  = size_reg;
      latch_next = latch_reg;
      hs_next    = hs_reg;
      rdata_next = 32'h0;

      // Handshake engine
      case (hs_reg)
         BPDMA_HS_IDLE: begin
            if (!ctrl_reg[BPDMA_BIT_DONE] && !ack_s &&
                (rd_ok || ctrl_reg[BPDMA_BIT_H2B])) begin
               hs_next = BPDMA_HS_REQ;
            end
         end
         BPDMA_HS_REQ: begin
            if (ack_s) begin
               hs_next = BPDMA_HS_WAIT_REL;
            end
         end
         BPDMA_HS_WAIT_REL: begin
            if (!ack_s) begin
               hs_next = BPDMA_HS_IDLE;
               if (ctrl_reg[BPDMA_BIT_B2H]) begin
                  if (rp_reg == sp_reg) begin
                     ctrl_next[BPDMA_BIT_DONE] = 1'b1;
                  end else begin
                     rp_next = rp_inc;
                  end
               end else if (ctrl_reg[BPDMA_BIT_H2B]) begin
                  if (wp_reg == sp_reg) begin
                     ctrl_next[BPDMA_BIT_DONE] = 1'b1;
                  end else begin
                     wp_next = wp_inc;
                  end
               end
            end
         end
         default: hs_next = BPDMA_HS_IDLE;
      endcase

      // Device byte into the buffer advances the write pointer
      if (mem_a_we) begin
         wp_next = wp_inc;
      end else if (strb_edge) begin
         rp_next = rp_inc;
      end

      // Register writes override engine updates
      if (wr_hit) begin
         case (a_word)
            BPDMA_IDX_DMA_CTRL: begin
               ctrl_next[7:6] = wbyte[7:6];
               ctrl_next[4:2] = wbyte[4:2];
               if ((wbyte[BPDMA_BIT_H2B] & ~ctrl_reg[BPDMA_BIT_H2B]) |
                   (wbyte[BPDMA_BIT_B2H] & ~ctrl_reg[BPDMA_BIT_B2H])) begin
                  ctrl_next[BPDMA_BIT_DONE] = 1'b0;
               end
            end
            BPDMA_IDX_BUF_SIZE: size_next = {wbyte, 8'hff};
            BPDMA_IDX_RESET: begin
               rp_next = '0;
               wp_next = '0;
               sp_next = '0;
            end
            BPDMA_IDX_RP_LO: rp_next[7:0] = wbyte;
            BPDMA_IDX_RP_HI: begin
               rp_next[PW-1:8] = wbyte[PW-9:0];
               if (ctrl_reg[BPDMA_BIT_DIR]) latch_next = wbyte;
            end
            BPDMA_IDX_WP_LO: wp_next[7:0] = wbyte;
            BPDMA_IDX_WP_HI: begin
               wp_next[PW-1:8] = wbyte[PW-9:0];
               if (!ctrl_reg[BPDMA_BIT_DIR]) latch_next = wbyte;
            end
            BPDMA_IDX_SP_LO, BPDMA_IDX_SP_HI: begin
               if (a_word == BPDMA_IDX_SP_LO) begin
                  sp_next[7:0] = wbyte;
               end else begin
                  sp_next[PW-1:8] = wbyte[PW-9:0];
               end
               // New stop address: clear done and keep the DMA going
               ctrl_next[BPDMA_BIT_DONE] = 1'b0;
            end
            default: ;
         endcase
      end

      if (reg_rd && reg_addr[1:0] == 2'h0) begin
         case (a_word)
            BPDMA_IDX_DMA_CTRL: begin
               rdata_next[7:0] = ctrl_reg;
               rdata_next[BPDMA_BIT_ACK] = ack_s;
            end
            BPDMA_IDX_BUF_SIZE: rdata_next[7:0] = size_reg[15:8];
            BPDMA_IDX_RP_LO:    rdata_next[7:0] = rp_reg[7:0];
            BPDMA_IDX_RP_HI:    rdata_next[7:0] = rp_reg[15:8];
            BPDMA_IDX_WP_LO:    rdata_next[7:0] = wp_reg[7:0];
            BPDMA_IDX_WP_HI:    rdata_next[7:0] = wp_reg[15:8];
            BPDMA_IDX_SP_LO:    rdata_next[7:0] = sp_reg[7:0];
            BPDMA_IDX_SP_HI:    rdata_next[7:0] = sp_reg[15:8];
            BPDMA_IDX_LATCH:    rdata_next[7:0] = latch_reg;
            default:            rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg  <= BPDMA_CTRL_RST;
         rp_reg    <= BPDMA_PTR_RST;
         wp_reg    <= BPDMA_PTR_RST;
         sp_reg    <= BPDMA_PTR_RST;
         size_reg  <= BPDMA_SIZE_RST;
         latch_reg <= 8'h00;
         rdata_reg <= 32'h0;
         hs_reg    <= BPDMA_HS_IDLE;
      end else begin
         ctrl_reg  <= ctrl_next;
         rp_reg    <= rp_next;
         wp_reg    <= wp_next;
         sp_reg    <= sp_next;
         size_reg  <= size_next;
         latch_reg <= latch_next;
         rdata_reg <= rdata_next;
         hs_reg    <= hs_next;
      end
   end

   assign reg_rdata  = rdata_reg;
   assign host_req   = (hs_reg == BPDMA_HS_REQ);
   assign host_rdata = host_q;
   assign dev_rdata  = dev_q;
   assign ext_latch  = latch_reg;
endmodule // bpdma_seq

// ===== tb/bpdma_seq_chk_sva.sv
`timescale 1ns/10ps
module bpdma_seq_chk
   import bpdma_pkg::*;
(
   // Clock and reset
   input wire logic                    core_clk,
   input wire logic                    rst,
   // Watched ports
   input wire logic [BPDMA_ADDR_W-1:0] reg_addr,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [31:0]             reg_rdata,
   input wire logic                    device_byte_strobe,
   input wire logic                    host_ack,
   input wire logic                    host_req,
   input wire logic [7:0]              ext_latch
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   a_rdata_upper_zero: assert property (reg_rd |=> reg_rdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_misalign_zero: assert property (reg_rd && reg_addr[1:0] != 2'h0
      |=> reg_rdata == 32'h0) else $error("misaligned read not zero");
   a_req_drops: assert property ($rose(host_ack) |-> ##[1:4] !host_req)
      else $error("request held after acknowledge");
   a_req_waits: assert property (host_req && !host_ack && !reg_wr |=> host_req)
      else $error("request dropped without acknowledge");
   a_req_ack_low: assert property ($rose(host_req) |-> !host_ack)
      else $error("request raised with acknowledge high");
   a_stop_clears_done: assert property (
      reg_wr && reg_addr == {BPDMA_IDX_SP_LO, 2'h0} ##2
      reg_rd && reg_addr == {BPDMA_IDX_DMA_CTRL, 2'h0} |=> !reg_rdata[5])
      else $error("done not cleared by stop write");
   a_latch_kept: assert property (
      reg_wr && reg_addr == {BPDMA_IDX_RESET, 2'h0} |=> $stable(ext_latch))
      else $error("latch changed by reset register");
endmodule // bpdma_seq_chk

// ===== tb/bpdma_host_model.sv
`timescale 1ns/10ps
module bpdma_host_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Handshake
   input  wire logic       host_req,
   input  wire logic [7:0] host_rdata,
   input  wire logic       slow,
   output logic            host_ack,
   output logic [7:0]      host_wdata
);
   logic [7:0] rx [0:15];
   int         n_rx;
   int         k;
   initial begin
      host_ack = 1'b0;
      host_wdata = 8'h5a;
      n_rx = 0;
      forever begin
         @(posedge core_clk);
         if (host_req && !host_ack && !rst) begin
            repeat (slow ? 5 : 1) @(posedge core_clk);
            host_wdata <= 8'ha0 + n_rx[7:0];
            @(posedge core_clk);
            host_ack <= 1'b1;
            rx[n_rx[3:0]] <= host_rdata;
            for (k = 0; k < 20 && host_req; k++) @(posedge core_clk);
            host_ack <= 1'b0;
            // Released data lines must not keep showing the last byte
            host_wdata <= ~host_wdata;
            n_rx++;
         end
      end
   end
endmodule // bpdma_host_model

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
   import bpdma_pkg::*;
   localparam logic [7:0] CT = BPDMA_IDX_DMA_CTRL;
   logic                    core_clk = 1'b0;
   logic                    rst = 1'b1;
   logic [BPDMA_ADDR_W-1:0] reg_addr = '0;
   logic [31:0]             reg_wdata = '0;
   logic                    reg_wr = 1'b0;
   logic                    reg_rd = 1'b0;
   logic                    device_byte_strobe = 1'b0;
   logic [7:0]              dev_wdata = 8'h0;
   logic                    slow = 1'b0;
   logic                    host_ack, host_req;
   logic [7:0]              host_wdata, host_rdata, dev_rdata, ext_latch;
   logic [31:0]             reg_rdata;
   int                      failures = 0;
   int                      n_tests = 0;
   int                      base;
   always #2.5 core_clk = ~core_clk;
   bpdma_seq u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .device_byte_strobe(device_byte_strobe),
      .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .host_ack(host_ack),
      .host_wdata(host_wdata), .host_req(host_req),
      .host_rdata(host_rdata), .ext_latch(ext_latch));
   bpdma_host_model u_host (.core_clk(core_clk), .rst(rst),
      .host_req(host_req), .host_rdata(host_rdata), .slow(slow),
      .host_ack(host_ack), .host_wdata(host_wdata));
   task automatic give_verdict();
      if (failures == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string w, input logic [15:0] s, e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s: expected %h, seen %h", w, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] idx, d);
      @(posedge core_clk);
      reg_addr <= {idx, 2'h0};
      reg_wdata <= {24'h0, d};
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [7:0] d,
                     input logic [1:0] lo = 2'h0);
      @(posedge core_clk);
      reg_addr <= {idx, lo};
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata[7:0];
   endtask
   task automatic cr(input string w, input logic [7:0] idx, e);
      logic [7:0] d;
      rd(idx, d);
      chk(w, {8'h0, d}, {8'h0, e});
   endtask
   task automatic cp(input string w, input logic [7:0] idx, input logic [15:0] e);
      logic [7:0] l, h;
      rd(idx, l);
      rd(idx + 8'h1, h);
      chk(w, {h, l}, e);
   endtask
   task automatic wait_done();
      logic [7:0] c;
      int i;
      for (i = 0; i < 100; i++) begin
         rd(CT, c);
         if (c[5] === 1'b1) break;
      end
      if (i == 100) begin
         failures++;
         give_verdict();
      end
   endtask
   task automatic strobe(input logic [7:0] d);
      @(posedge core_clk);
      dev_wdata <= d;
      device_byte_strobe <= 1'b1;
      repeat (2) @(posedge core_clk);
      device_byte_strobe <= 1'b0;
      repeat (5) @(posedge core_clk);
   endtask
   task automatic t_write();
      slow <= 1'b1;
      cr("control", CT, 8'h00);
      cp("stop", BPDMA_IDX_SP_LO, 16'h0);
      wr(BPDMA_IDX_RESET, 8'h0);
      wr(CT, 8'h00);
      wr(BPDMA_IDX_WP_HI, 8'h0);
      wr(BPDMA_IDX_SP_LO, 8'h03);
      wr(CT, 8'h04);
      wait_done();
      cp("write pointer", BPDMA_IDX_WP_LO, 16'h3);
      wr(BPDMA_IDX_SP_LO, 8'h05);
      cr("control", CT, 8'h04);
      wait_done();
      cp("write pointer", BPDMA_IDX_WP_LO, 16'h5);
      wr(CT, 8'h00);
      cr("control", CT, 8'h20);
      chk("device data", {8'h0, dev_rdata}, 16'h00a6);
   endtask
   task automatic t_read();
      slow <= 1'b0;
      wr(BPDMA_IDX_RESET, 8'h0);
      cp("write pointer", BPDMA_IDX_WP_LO, 16'h0);
      cp("stop", BPDMA_IDX_SP_LO, 16'h0);
      wr(CT, 8'h10);
      wr(BPDMA_IDX_RP_HI, 8'h0);
      chk("latch", {8'h0, ext_latch}, 16'h0);
      for (int i = 0; i < 4; i++) strobe(8'h30 + i[7:0]);
      cp("write pointer", BPDMA_IDX_WP_LO, 16'h4);
      base = u_host.n_rx;
      wr(BPDMA_IDX_SP_LO, 8'h03);
      wr(CT, 8'h18);
      wait_done();
      cp("read pointer", BPDMA_IDX_RP_LO, 16'h3);
      for (int i = 0; i < 4; i++)
         chk("host byte", {8'h0, u_host.rx[(base + i) % 16]}, 16'h30 + 16'(i));
      cp("read pointer", BPDMA_IDX_RP_LO, 16'h3);
      strobe(8'h34);
      strobe(8'h35);
      wr(BPDMA_IDX_SP_LO, 8'h05);
      wait_done();
      cp("read pointer", BPDMA_IDX_RP_LO, 16'h5);
      wr(CT, 8'h10);
      cr("control", CT, 8'h30);
      wr(CT, 8'h00);
      strobe(8'h36);
      cp("read pointer", BPDMA_IDX_RP_LO, 16'h6);
   endtask
   task automatic t_wrap();
      logic [7:0] d;
      wr(BPDMA_IDX_BUF_SIZE, 8'h00);
      wr(CT, 8'h10);
      wr(BPDMA_IDX_WP_LO, 8'hff);
      wr(BPDMA_IDX_WP_HI, 8'h00);
      strobe(8'h77);
      cp("write pointer", BPDMA_IDX_WP_LO, 16'h0);
      cr("unmapped", 8'h70, 8'h00);
      rd(CT, d, 2'h1);
      chk("misaligned", {8'h0, d}, 16'h0);
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      t_write();
      t_read();
      t_wrap();
      give_verdict();
   end
endmodule // tb
bind bpdma_seq bpdma_seq_chk u_chk (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .device_byte_strobe(device_byte_strobe),
   .host_ack(host_ack), .host_req(host_req), .ext_latch(ext_latch));
